// file: common/ccrp_pkg.sv
// constants and carrier types of the card reader/punch controller
// assumes a 50 MHz host clock and a 16-bit host i/o word
package ccrp_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int COLS_PER_CARD = 80;
    localparam int COL_W = 12;
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W = 7;
    // longest waits for end of operation after the channel stops
    localparam int PUNCH_EOP_US = 9000;
    localparam int READ_EOP_US = 1000;
    localparam int PUNCH_EOP_CYC = PUNCH_EOP_US * (CLK_HZ / 1_000_000);
    localparam int READ_EOP_CYC = READ_EOP_US * (CLK_HZ / 1_000_000);
    localparam logic [1:0] ST_COMMON = 2'h0;
    localparam logic [1:0] ST_READER = 2'h1;
    localparam logic [1:0] ST_PUNCH = 2'h2;
    // function word bits
    localparam int FN_CLR_INT = 0;
    localparam int FN_CLR_CTL = 1;
    localparam int FN_DATA_IE = 2;
    localparam int FN_EOP_IE = 3;
    localparam int FN_ALM_IE = 4;
    localparam int FN_FEED = 5;
    // status word bits
    localparam int SB_READY = 0;
    localparam int SB_BUSY = 1;
    localparam int SB_INT = 2;
    localparam int SB_DATA = 3;
    localparam int SB_EOP = 4;
    localparam int SB_ALARM = 5;
    localparam int SB_LOST = 6;
    localparam int SB_PROT = 7;
    typedef enum logic [1:0] {PH_IDLE, PH_RUN, PH_DRAIN} ccrp_phase_t;
    typedef struct packed {
        logic req;
        logic [1:0] station;
        logic dir_out;
        logic is_func;
        logic prot_prog;
        logic [WORD_W-1:0] wdata;
    } ccrp_req_t;
    typedef struct packed {
        logic reply;
        logic reject;
        logic [WORD_W-1:0] rdata;
    } ccrp_rsp_t;
    typedef struct packed {
        ccrp_phase_t ph;
        logic [CNT_W-1:0] cnt;
        logic data;
        logic eop;
        logic lost;
        logic den;
        logic eie;
        logic aie;
    } ccrp_stn_t;
endpackage : ccrp_pkg

// file: hdl/ccrp_fifo.sv
// column word fifo between host output and punch mechanism
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
module ccrp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ccrp_fifo_st_t;

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("fifo depth must be a power of two");
    end

    ccrp_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready_out = (st.cnt != DEPTH[AW:0]);
    assign out_valid_out = (st.cnt != '0);
    assign out_data_out = mem[st.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        next_st = st;
        if (push)
            next_st.wp = st.wp + 1'b1;
        if (pop)
            next_st.rp = st.rp + 1'b1;
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        if (flush_in)
            next_st = '0;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= next_st;
    end

    // storage needs no reset; the counters guard every read
    always_ff @(posedge clk_in) begin
        if (push)
            mem[st.wp] <= in_data_in;
    end
endmodule : ccrp_fifo

// file: hdl/ccrp_ctrl.sv
// card reader/punch controller seen from the host i/o bus
// assumes requests are one-cycle pulses synchronous to clk_in
//
// Contract
// [R1] one punch function: feed, clear, interrupt enables
// [R2] punch accepts exactly eighty columns per card
// [R3] punch end of operation within 9 ms
// [R4] eighty-first punch word gets external reject
// [R5] overlong punch: end of operation while channel busy
// [R6] read before column ready is rejected; host retries
// [R7] reader busy and ready after accepted column
// [R8] available column shows data, busy, ready
// [R9] one data interrupt per column, eighty per card
// [R10] after card: end of operation, interrupt, ready
// [R11] buffered read ends within 1 ms
// [R12] reader supplies only eighty words per card
// [R13] protect switch shows protected, ready on common
// [R14] protected: unprotected functions get external reject
// [R15] protected idle punch: protected, data, ready
// [R16] alarm shows alarm, interrupt, not ready
// [R17] alarm interrupt delivered once its enable set
// [R18] alarm not ready: reader and punch reject
// [R19] stations 0, 1, 2; reply or reject always
`timescale 1ns/1ps
module ccrp_ctrl #(
    parameter int PUNCH_EOP_CYC = ccrp_pkg::PUNCH_EOP_CYC,
    parameter int READ_EOP_CYC = ccrp_pkg::READ_EOP_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire ccrp_pkg::ccrp_req_t io_req_in,
    output ccrp_pkg::ccrp_rsp_t io_rsp_out,
    input wire logic protect_sw_in,
    input wire logic alarm_in,
    input wire logic rd_col_valid_in,
    input wire logic [ccrp_pkg::COL_W-1:0] rd_col_data_in,
    output logic pun_col_valid_out,
    output logic [ccrp_pkg::COL_W-1:0] pun_col_data_out,
    input wire logic pun_col_ready_in,
    output logic data_irq_out,
    output logic eop_irq_out,
    output logic alarm_irq_out
);
    import ccrp_pkg::*;

    typedef struct packed {
        ccrp_stn_t rd;
        ccrp_stn_t pu;
        logic [COL_W-1:0] rd_hold;
        ccrp_rsp_t rsp;
        logic pv;
        logic [COL_W-1:0] pd;
        logic dirq;
        logic eirq;
        logic airq;
    } ccrp_st_t;

    initial begin
        if (PUNCH_EOP_CYC < 2 || READ_EOP_CYC < 2)
            $error("end of operation limits too short");
    end

    ccrp_st_t st, next_st;
    logic f_ready, f_valid, f_pop, push, flush;
    logic [COL_W-1:0] f_data;
    logic pu_data, rd_int, pu_int, lock;
    logic rd_take, is_stat, is_fn;

    ccrp_fifo #(
        .WIDTH(COL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .flush_in(flush),
        .in_valid_in(push),
        .in_data_in(io_req_in.wdata[COL_W-1:0]),
        .in_ready_out(f_ready),
        .out_valid_out(f_valid),
        .out_data_out(f_data),
        .out_ready_in(f_pop)
    );

    // output stage keeps the punch port straight from a flop
    assign f_pop = !st.pv || pun_col_ready_in;

    // idle punch with no finished card offers data
    assign pu_data = (st.pu.ph == PH_IDLE && !st.pu.eop) ||
                     (st.pu.ph == PH_RUN && f_ready); // see [R15]
    assign rd_int = (st.rd.data && st.rd.den) || (st.rd.eop && st.rd.eie);
    assign pu_int = (pu_data && st.pu.den) || (st.pu.eop && st.pu.eie);
    // not-ready alarm, and protect for requests without prot_prog, lock stations 1 and 2
    assign lock = alarm_in ||
        (protect_sw_in && !io_req_in.prot_prog); // see [R14] [R18]
    assign is_stat = io_req_in.is_func && !io_req_in.dir_out;
    assign is_fn = io_req_in.is_func && io_req_in.dir_out;
    assign rd_take = io_req_in.req && !is_stat && !lock && !is_fn &&
        io_req_in.station == ST_READER && !io_req_in.dir_out &&
        st.rd.data; // see [R6]
    assign push = io_req_in.req && !is_stat && !lock && !is_fn &&
        io_req_in.station == ST_PUNCH && io_req_in.dir_out &&
        st.pu.ph == PH_RUN && f_ready; // see [R2] [R4]
    assign flush = io_req_in.req && is_fn && !lock &&
        io_req_in.station == ST_PUNCH &&
        (io_req_in.wdata[FN_CLR_CTL] || io_req_in.wdata[FN_FEED]);

    function automatic ccrp_stn_t apply_fn(ccrp_stn_t s,
                                           logic [WORD_W-1:0] w);
        ccrp_stn_t r;
        r = s;
        if (w[FN_CLR_INT]) begin
            r.den = 1'b0;
            r.eie = 1'b0;
            r.aie = 1'b0;
        end
        // clear keeps the end-of-operation flag for the host to see
        if (w[FN_CLR_CTL]) begin
            r.ph = PH_IDLE;
            r.cnt = '0;
            r.data = 1'b0;
            r.lost = 1'b0;
        end
        r.den = r.den | w[FN_DATA_IE];
        r.eie = r.eie | w[FN_EOP_IE];
        r.aie = r.aie | w[FN_ALM_IE];
        if (w[FN_FEED]) begin
            r.ph = PH_RUN;
            r.cnt = '0;
            r.eop = 1'b0;
            r.data = 1'b0;
        end
        return r;
    endfunction : apply_fn

    function automatic logic [WORD_W-1:0] stat_word(ccrp_stn_t s,
        logic dat, logic irq, logic alm, logic prot);
        logic [WORD_W-1:0] w;
        w = '0;
        w[SB_READY] = !alm;
        w[SB_BUSY] = (s.ph != PH_IDLE);
        w[SB_DATA] = dat;
        w[SB_EOP] = s.eop;
        w[SB_LOST] = s.lost;
        w[SB_ALARM] = alm || s.lost;
        w[SB_INT] = irq || alm || s.lost;
        w[SB_PROT] = prot;
        return w;
    endfunction : stat_word

    always_comb begin
        next_st = st;
        next_st.rsp = '0;
        if (f_pop) begin
            next_st.pv = f_valid;
            next_st.pd = f_data;
        end
        if (io_req_in.req) begin
            next_st.rsp.reject = 1'b1; // see [R19]
            if (is_stat && io_req_in.station != 2'h3) begin
                next_st.rsp.reject = 1'b0;
                next_st.rsp.reply = 1'b1;
                case (io_req_in.station)
                    ST_READER: next_st.rsp.rdata = stat_word(st.rd,
                        st.rd.data, rd_int, alarm_in, protect_sw_in);
                    ST_PUNCH: next_st.rsp.rdata = stat_word(st.pu,
                        pu_data, pu_int, alarm_in, protect_sw_in);
                    default: begin
                        next_st.rsp.rdata[SB_READY] = !alarm_in;
                        next_st.rsp.rdata[SB_INT] = alarm_in ||
                            rd_int || pu_int; // see [R16]
                        next_st.rsp.rdata[SB_ALARM] = alarm_in;
                        next_st.rsp.rdata[SB_PROT] =
                            protect_sw_in; // see [R13]
                    end
                endcase
            end else if (is_fn && !lock &&
                         io_req_in.station == ST_READER) begin
                next_st.rsp = '{reply: 1'b1, reject: 1'b0, rdata: '0};
                next_st.rd = apply_fn(next_st.rd, io_req_in.wdata);
            end else if (is_fn && !lock &&
                         io_req_in.station == ST_PUNCH) begin
                next_st.rsp = '{reply: 1'b1, reject: 1'b0, rdata: '0};
                next_st.pu = apply_fn(st.pu, io_req_in.wdata); // see [R1]
                if (flush)
                    next_st.pv = 1'b0;
            end else if (rd_take) begin
                next_st.rsp.reply = 1'b1;
                next_st.rsp.reject = 1'b0;
                next_st.rsp.rdata = {{(WORD_W-COL_W){1'b0}}, st.rd_hold};
                next_st.rd.data = 1'b0;
                next_st.rd.cnt = st.rd.cnt + 1'b1; // see [R7]
                // eightieth column ends the card; no more are offered
                if (st.rd.cnt == CNT_W'(COLS_PER_CARD - 1)) begin
                    next_st.rd.ph = PH_IDLE; // see [R12]
                    next_st.rd.eop = 1'b1; // see [R10] [R11]
                end
            end else if (push) begin
                next_st.rsp.reply = 1'b1;
                next_st.rsp.reject = 1'b0;
                next_st.pu.cnt = st.pu.cnt + 1'b1;
                if (st.pu.cnt == CNT_W'(COLS_PER_CARD - 1))
                    next_st.pu.ph = PH_DRAIN; // see [R2]
            end
        end
        // column arrival after the host access: a take frees the hold,
        // and a lost-data set beats a clear in the same cycle
        if (rd_col_valid_in && st.rd.ph == PH_RUN) begin
            if (st.rd.data && !rd_take)
                next_st.rd.lost = 1'b1;
            else if (next_st.rd.ph == PH_RUN) begin
                next_st.rd_hold = rd_col_data_in;
                next_st.rd.data = 1'b1; // see [R8]
            end
        end
        // card done once the last column has left the output stage
        if (st.pu.ph == PH_DRAIN && !f_valid && !st.pv &&
            next_st.pu.ph == PH_DRAIN) begin
            next_st.pu.ph = PH_IDLE;
            next_st.pu.eop = 1'b1; // see [R3] [R5]
        end
        next_st.dirq = (st.rd.data && st.rd.den) ||
            (pu_data && st.pu.ph == PH_RUN && st.pu.den); // see [R9]
        next_st.eirq = (st.rd.eop && st.rd.eie) || (st.pu.eop && st.pu.eie);
        next_st.airq = (alarm_in || st.rd.lost) &&
            (st.rd.aie || st.pu.aie); // see [R17]
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            st <= '0;
        else
            st <= next_st;
    end

    assign io_rsp_out = st.rsp;
    assign pun_col_valid_out = st.pv;
    assign pun_col_data_out = st.pd;
    assign data_irq_out = st.dirq;
    assign eop_irq_out = st.eirq;
    assign alarm_irq_out = st.airq;

    // helper: cycles spent draining a punched card
    logic [31:0] drain_cyc;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in || st.pu.ph != PH_DRAIN)
            drain_cyc <= '0;
        else
            drain_cyc <= drain_cyc + 32'h1;
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_empty_read_reject: assert property ( // see [R6]
        io_req_in.req && !io_req_in.is_func && !io_req_in.dir_out &&
        io_req_in.station == ST_READER && !st.rd.data
        |=> io_rsp_out.reject && !io_rsp_out.reply)
        else $error("read with no column was not rejected");
    a_punch_count_max: assert property ( // see [R2]
        st.pu.cnt <= CNT_W'(COLS_PER_CARD))
        else $error("punch column count above a card");
    a_extra_word_refused: assert property ( // see [R4]
        io_req_in.req && !io_req_in.is_func && io_req_in.dir_out &&
        io_req_in.station == ST_PUNCH && st.pu.ph != PH_RUN
        |=> io_rsp_out.reject ##0 $stable(st.pu.cnt))
        else $error("extra punch word was accepted");
    a_protect_lockout: assert property ( // see [R14]
        io_req_in.req && !(io_req_in.is_func && !io_req_in.dir_out) &&
        protect_sw_in && !io_req_in.prot_prog
        |=> io_rsp_out.reject)
        else $error("protected function was not rejected");
    a_alarm_lockout: assert property ( // see [R18]
        io_req_in.req && alarm_in && !is_stat
        |=> io_rsp_out.reject && !io_rsp_out.reply)
        else $error("function during alarm was not rejected");
    a_status_reply: assert property ( // see [R19]
        io_req_in.req && is_stat && io_req_in.station != 2'h3
        |=> io_rsp_out.reply)
        else $error("status read got no reply");
    a_read_card_end: assert property ( // see [R10]
        rd_take && st.rd.cnt == CNT_W'(COLS_PER_CARD - 1) &&
        !io_req_in.is_func
        |=> st.rd.eop && st.rd.ph == PH_IDLE)
        else $error("eightieth column did not end the card");
    a_read_eop_irq: assert property ( // see [R11]
        st.rd.eop && st.rd.eie |=> eop_irq_out)
        else $error("reader end of operation interrupt missing");
    a_alarm_irq: assert property ( // see [R17]
        alarm_in && st.pu.aie ##1 alarm_in |=> alarm_irq_out)
        else $error("enabled alarm interrupt not raised");
    a_punch_eop_time: assert property ( // see [R3]
        drain_cyc < 32'(PUNCH_EOP_CYC))
        else $error("punch end of operation too late");
    a_common_status: assert property ( // see [R13] [R16]
        io_req_in.req && is_stat && io_req_in.station == ST_COMMON
        |=> io_rsp_out.rdata[SB_PROT] == $past(protect_sw_in) &&
            io_rsp_out.rdata[SB_READY] == !$past(alarm_in))
        else $error("common status wrong");

    c_punch_card: cover property (st.pu.ph == PH_DRAIN ##1
        st.pu.ph == PH_IDLE);
    c_read_card: cover property (rd_take && st.rd.cnt ==
        CNT_W'(COLS_PER_CARD - 1));
    c_prot_reject: cover property (io_req_in.req && lock &&
        protect_sw_in);
    c_lost_column: cover property (st.rd.lost);
endmodule : ccrp_ctrl

// file: bench/ccrp_mech.sv
// card mechanism model: reader column source and punch column sink
// assumes the controller clock; a reader card starts on start_in
`timescale 1ns/1ps
module ccrp_mech (
    input wire logic clk_in,
    input wire logic start_in,
    input wire logic stall_in,
    output logic rd_col_valid_out,
    output logic [ccrp_pkg::COL_W-1:0] rd_col_data_out,
    output logic pun_col_ready_out,
    input wire logic pun_col_valid_in,
    input wire logic [ccrp_pkg::COL_W-1:0] pun_col_data_in,
    output int pun_cnt_out,
    output logic [ccrp_pkg::COL_W-1:0] pun_last_out
);
    import ccrp_pkg::*;
    // one column past the card shows that the controller stops at 80
    int cols = COLS_PER_CARD + 1;
    int gap = 0;
    initial begin
        rd_col_valid_out = 1'b0;
        rd_col_data_out = 12'h000;
        pun_cnt_out = 0;
        pun_last_out = 12'h000;
    end
    // column gap leaves the host time to take each word
    always @(posedge clk_in) begin
        rd_col_valid_out <= 1'b0;
        rd_col_data_out <= ~rd_col_data_out;
        if (start_in) begin
            cols = 0;
            gap = 0;
        end else if (cols <= COLS_PER_CARD) begin
            gap = gap + 1;
            if (gap == 30) begin
                gap = 0;
                rd_col_valid_out <= 1'b1;
                rd_col_data_out <= 12'h555 ^ cols[11:0];
                cols = cols + 1;
            end
        end
        if (pun_col_valid_in === 1'b1 && pun_col_ready_out) begin
            pun_cnt_out <= pun_cnt_out + 1;
            pun_last_out <= pun_col_data_in;
        end
    end
    assign pun_col_ready_out = ~stall_in;
endmodule : ccrp_mech

// file: bench/testbench.sv
// self-checking bench of the reader/punch controller
// assumes the mechanism model on the column side; host bus driven here
`timescale 1ns/1ps
module testbench;
    import ccrp_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    ccrp_req_t req = '0;
    ccrp_rsp_t rsp;
    logic protect_sw = 1'b0;
    logic alarm = 1'b0;
    logic start = 1'b0;
    logic stall = 1'b0;
    logic prot_prog = 1'b0;
    logic rd_v, pun_v, pun_rdy, d_irq, e_irq, a_irq;
    logic [COL_W-1:0] rd_d, pun_d, pun_last;
    int pun_cnt;
    int num_errors = 0;
    int n_compared = 0;
    int d_rises = 0;
    logic d_prev = 1'b0;
    logic [1:0] rr;
    logic [15:0] rd;

    initial forever #10 clk_in = ~clk_in;

    ccrp_ctrl #(.PUNCH_EOP_CYC(200), .READ_EOP_CYC(200)) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .io_req_in(req),
        .io_rsp_out(rsp), .protect_sw_in(protect_sw), .alarm_in(alarm),
        .rd_col_valid_in(rd_v), .rd_col_data_in(rd_d),
        .pun_col_valid_out(pun_v), .pun_col_data_out(pun_d),
        .pun_col_ready_in(pun_rdy), .data_irq_out(d_irq),
        .eop_irq_out(e_irq), .alarm_irq_out(a_irq));

    ccrp_mech mech (
        .clk_in(clk_in), .start_in(start), .stall_in(stall),
        .rd_col_valid_out(rd_v), .rd_col_data_out(rd_d),
        .pun_col_ready_out(pun_rdy), .pun_col_valid_in(pun_v),
        .pun_col_data_in(pun_d), .pun_cnt_out(pun_cnt),
        .pun_last_out(pun_last));

    always @(posedge clk_in) begin
        d_prev <= d_irq;
        if (d_irq === 1'b1 && d_prev !== 1'b1)
            d_rises <= d_rises + 1;
    end

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic timeout();
        num_errors++;
        final_report();
    endtask : timeout

    // one request pulse, answer sampled after the following edge
    task automatic io(input logic [1:0] st, input logic dout,
                      input logic fn, input logic [15:0] wd);
        @(posedge clk_in);
        #1;
        req = '{1'b1, st, dout, fn, prot_prog, wd};
        @(posedge clk_in);
        #1;
        req.req = 1'b0;
        rr = {rsp.reply, rsp.reject};
        rd = rsp.rdata;
    endtask : io

    task automatic stat(input logic [1:0] st, input logic [15:0] exp);
        io(st, 1'b0, 1'b1, 16'h0000);
        chk(rr, 2'h2);
        chk(rd, exp);
    endtask : stat

    task automatic t_static();
        stat(ST_COMMON, 16'h0001);
        io(2'h3, 1'b0, 1'b1, 16'h0000);
        chk(rr, 2'h1);
        io(ST_COMMON, 1'b1, 1'b1, 16'h003F);
        chk(rr, 2'h1);
    endtask : t_static

    task automatic t_protect();
        protect_sw = 1'b1;
        stat(ST_COMMON, 16'h0081);
        io(ST_READER, 1'b1, 1'b1, 16'h003F);
        chk(rr, 2'h1);
        io(ST_PUNCH, 1'b1, 1'b1, 16'h003F);
        chk(rr, 2'h1);
        stat(ST_READER, 16'h0081);
        stat(ST_PUNCH, 16'h0089);
        // a protected program may still command the stations
        prot_prog = 1'b1;
        io(ST_PUNCH, 1'b1, 1'b1, 16'h0003);
        chk(rr, 2'h2);
        prot_prog = 1'b0;
        protect_sw = 1'b0;
    endtask : t_protect

    task automatic t_alarm();
        io(ST_PUNCH, 1'b1, 1'b1, 16'h0012);
        chk(rr, 2'h2);
        chk(a_irq, 1'b0);
        alarm = 1'b1;
        stat(ST_COMMON, 16'h0024);
        chk(a_irq, 1'b1);
        io(ST_READER, 1'b1, 1'b1, 16'h003F);
        chk(rr, 2'h1);
        io(ST_PUNCH, 1'b1, 1'b1, 16'h003F);
        chk(rr, 2'h1);
        io(ST_PUNCH, 1'b0, 1'b1, 16'h0000);
        chk(rd & 16'hFFF7, 16'h0024);
        alarm = 1'b0;
        io(ST_PUNCH, 1'b1, 1'b1, 16'h0003);
        chk(rr, 2'h2);
    endtask : t_alarm

    // stalled mechanism fills the fifo; host retries refused words
    task automatic t_punch();
        int i, k;
        logic refused;
        refused = 1'b0;
        stall = 1'b1;
        io(ST_PUNCH, 1'b1, 1'b1, 16'h003A);
        chk(rr, 2'h2);
        for (i = 0; i < 80; i++) begin
            rr = 2'h1;
            for (k = 0; k < 200 && rr != 2'h2; k++) begin
                io(ST_PUNCH, 1'b1, 1'b0, {4'h0, 12'hA5A ^ i[11:0]});
                if (rr == 2'h1) begin
                    refused = 1'b1;
                    stall = 1'b0;
                end
            end
            if (rr != 2'h2) timeout();
        end
        chk(refused, 1'b1);
        io(ST_PUNCH, 1'b1, 1'b0, 16'h0FFF);
        chk(rr, 2'h1);
        // channel keeps offering the extra word until the card ends
        for (k = 0; k < 100 && e_irq !== 1'b1; k++) begin
            io(ST_PUNCH, 1'b1, 1'b0, 16'h0FFF);
            chk(rr, 2'h1);
        end
        chk(e_irq, 1'b1);
        chk(16'(pun_cnt), 16'd80);
        chk(pun_last, 12'hA5A ^ 12'd79);
        stat(ST_PUNCH, 16'h0015);
    endtask : t_punch

    task automatic t_read();
        int i, k;
        io(ST_READER, 1'b1, 1'b1, 16'h003E);
        chk(rr, 2'h2);
        start = 1'b1;
        @(posedge clk_in);
        #1;
        start = 1'b0;
        io(ST_READER, 1'b0, 1'b0, 16'h0000);
        chk(rr, 2'h1);
        for (i = 0; i < 80; i++) begin
            for (k = 0; k < 100 && d_irq !== 1'b1; k++) begin
                @(posedge clk_in);
                #1;
            end
            if (d_irq !== 1'b1) timeout();
            stat(ST_READER, 16'h000F);
            io(ST_READER, 1'b0, 1'b0, 16'h0000);
            chk(rr, 2'h2);
            chk(rd, {4'h0, 12'h555 ^ i[11:0]});
            if (i < 79) stat(ST_READER, 16'h0003);
        end
        for (k = 0; k < 200 && e_irq !== 1'b1; k++) begin
            @(posedge clk_in);
            #1;
        end
        chk(e_irq, 1'b1);
        chk(16'(d_rises), 16'd80);
        stat(ST_READER, 16'h0015);
        // the mechanism offers an eighty-first column; it must not land
        repeat (40) @(posedge clk_in);
        #1;
        io(ST_READER, 1'b0, 1'b0, 16'h0000);
        chk(rr, 2'h1);
        stat(ST_READER, 16'h0015);
    endtask : t_read

    // host ignores the columns; the second one finds the hold full
    task automatic t_lost();
        io(ST_READER, 1'b1, 1'b1, 16'h0033);
        chk(rr, 2'h2);
        start = 1'b1;
        @(posedge clk_in);
        #1;
        start = 1'b0;
        repeat (70) @(posedge clk_in);
        #1;
        stat(ST_READER, 16'h006F);
        chk(a_irq, 1'b1);
        io(ST_READER, 1'b1, 1'b1, 16'h0002);
        chk(rr, 2'h2);
        stat(ST_READER, 16'h0001);
        chk(a_irq, 1'b0);
    endtask : t_lost

    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        rst_n_in = 1'b1;
        t_static();
        t_protect();
        t_alarm();
        t_punch();
        t_read();
        t_lost();
        final_report();
    end
endmodule : testbench
